// file: kms_pkg.sv
// Purpose: Shared constants for the keypad matrix scanner
// Assumes: APB slave, 32-bit data, word-aligned registers
// Notes:   Offsets are byte addresses
package kms_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] KMS_OFF_COLCTRL = 8'h00;
  localparam logic [7:0] KMS_OFF_ROWSEL  = 8'h04;
  localparam logic [7:0] KMS_OFF_ROWIN   = 8'h08;
  localparam logic [7:0] KMS_OFF_STATUS  = 8'h0c;
  localparam logic [7:0] KMS_OFF_CLEAR   = 8'h10;
  localparam logic [7:0] KMS_OFF_ENABLE  = 8'h14;
  localparam logic [7:0] KMS_OFF_WAKE    = 8'h18;

  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int KMS_MODE_LSB  = 0;
  localparam int KMS_MODE_W    = 2;
  localparam int KMS_COLIX_LSB = 4;
  localparam int KMS_COLIX_W   = 3;
  localparam int KMS_STAT_KEY  = 0;
  localparam int KMS_STAT_ROW  = 1;
  localparam int KMS_STAT_W    = 2;

  localparam logic [1:0] KMS_STAT_RST   = 2'h0;
  localparam logic [7:0] KMS_ROWSEL_RST = 8'hff;
  localparam logic [1:0] KMS_WAKE_RST   = 2'h3;

  // Column drive modes; reset state leaves the matrix undriven
  typedef enum logic [1:0] {
    KMS_COL_HIZ  = 2'b00,
    KMS_COL_LOW  = 2'b01,
    KMS_COL_HIGH = 2'b10,
    KMS_COL_ONE  = 2'b11
  } kms_colmode_t;
endpackage

// file: kms_col_driver.sv
// Purpose: Column strobe driver for an 8-column key matrix
// Assumes: Output enable high while the pin is driven
// Notes:   Registered outputs, one cycle after a mode change
`timescale 1ns/1ns
module kms_col_driver #(
  parameter int COLS = 8
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire kms_pkg::kms_colmode_t colMode,
  input  wire logic [$clog2(COLS)-1:0] colIndex,
  output logic [COLS-1:0]           colOut,
  output logic [COLS-1:0]           colOe
);
  import kms_pkg::*;

  logic [COLS-1:0] colOutNext;
  logic [COLS-1:0] colOeNext;

  always_comb begin
    colOutNext = '0;
    colOeNext  = '0;
    unique case (colMode)
      KMS_COL_HIZ: begin
        colOutNext = '0;
        colOeNext  = '0;
      end
      KMS_COL_LOW: begin
        colOutNext = '0;
        colOeNext  = '1;
      end
      KMS_COL_HIGH: begin
        colOutNext = '1;
        colOeNext  = '1;
      end
      KMS_COL_ONE: begin
        colOutNext[colIndex] = 1'b1;
        colOeNext[colIndex]  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      colOut <= '0;
      colOe  <= '0;
    end else begin
      colOut <= colOutNext;
      colOe  <= colOeNext;
    end
  end
endmodule // kms_col_driver

// file: kms_scanner.sv
// Purpose: Keypad matrix scanner top with APB registers
// Assumes: Row sense pins are asynchronous and synchronised here
// Notes:   Status bits are sticky; a set in the same cycle as a clear wins
// Functional notes
// - Provide an 8-bit column driver that can strobe each column.
// - One selected column driven high, all other columns high impedance.
// - Collective modes: all columns low, all high, or all undriven.
// - Keyboard interrupt is OR of selected row inputs when pins are inputs.
// - Keyboard interrupt wakes the system from standby and idle.
// - Scan an 8x8 matrix with no external logic.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
module kms_scanner #(
  parameter int ROWS = 8,
  parameter int COLS = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [ROWS-1:0]   rowSensePort,
  input  wire logic              rowIsInput,
  output logic [COLS-1:0]        colOut,
  output logic [COLS-1:0]        colOe,
  output logic                   keyIrq,
  output logic                   wakeReq,
  output logic                   irq
);
  import kms_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [ROWS-1:0] rowMeta_reg;
  logic [ROWS-1:0] rowSync_reg;
  logic [1:0]      dirMeta_reg;

  // Rows come straight from the key switches, so they are bounced and asynchronous
  // Bounce is left to software; it sees every level the sync flops pass on
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rowMeta_reg <= '0;
      rowSync_reg <= '0;
      dirMeta_reg <= 2'h0;
    end else begin
      rowMeta_reg <= rowSensePort;
      rowSync_reg <= rowMeta_reg;
      dirMeta_reg <= {dirMeta_reg[0], rowIsInput};
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Mode and index are written together, so one scan step is one write
  kms_colmode_t      colMode_reg;
  logic [KMS_COLIX_W-1:0] colIndex_reg;
  logic [ROWS-1:0]   rowSel_reg;
  logic [KMS_STAT_W-1:0] status_reg;
  logic [KMS_STAT_W-1:0] enable_reg;
  logic [1:0]        wakeEn_reg;
  logic              keyIrq_reg;
  logic              keyIrqPrev_reg;

  logic wrEn;
  logic rdEn;
  logic knownAddr;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // One decode for every register write strobe, so all writers agree on timing
  function automatic logic wrHit(
    input logic       en,
    input logic [7:0] addr,
    input logic [7:0] off
  );
    return en && (addr == off);
  endfunction

  assign wrEn = psel && penable && pwrite;
  // Read data is loaded in the setup cycle so it already stands in the access phase
  assign rdEn = psel && !penable && !pwrite;
  // No wait states: every access finishes in its first access cycle
  assign pready = 1'b1;

  always_comb begin
    unique case (paddr)
      KMS_OFF_COLCTRL, KMS_OFF_ROWSEL, KMS_OFF_ROWIN, KMS_OFF_STATUS,
      KMS_OFF_CLEAR, KMS_OFF_ENABLE, KMS_OFF_WAKE: knownAddr = 1'b1;
      default:                                    knownAddr = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !knownAddr;

  // Column control: mode and selected column
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      colMode_reg  <= KMS_COL_HIZ;
      colIndex_reg <= '0;
    end else if (wrHit(wrEn, paddr, KMS_OFF_COLCTRL)) begin
      colMode_reg  <= kms_colmode_t'(pwdata[KMS_MODE_LSB +: KMS_MODE_W]);
      colIndex_reg <= pwdata[KMS_COLIX_LSB +: KMS_COLIX_W];
    end
  end

  // Row select: all rows take part after reset, so any key can wake the system
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rowSel_reg <= KMS_ROWSEL_RST;
    end else if (wrHit(wrEn, paddr, KMS_OFF_ROWSEL)) begin
      rowSel_reg <= pwdata[ROWS-1:0];
    end
  end

  // Interrupt enable: nothing reaches irq until software asks for it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      enable_reg <= KMS_STAT_RST;
    end else if (wrHit(wrEn, paddr, KMS_OFF_ENABLE)) begin
      enable_reg <= pwdata[KMS_STAT_W-1:0];
    end
  end

  // Wake enables: bit 0 standby, bit 1 idle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wakeEn_reg <= KMS_WAKE_RST;
    end else if (wrHit(wrEn, paddr, KMS_OFF_WAKE)) begin
      wakeEn_reg <= pwdata[1:0];
    end
  end

  // ----------------------------------------
  // Keyboard interrupt
  // ----------------------------------------
  // Level follows the OR of selected rows; rows not in input mode give nothing
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      keyIrq_reg     <= 1'b0;
      keyIrqPrev_reg <= 1'b0;
    end else begin
      keyIrq_reg     <= dirMeta_reg[1] && |(rowSync_reg & rowSel_reg);
      // Previous level only feeds the press bit of the status register
      keyIrqPrev_reg <= keyIrq_reg;
    end
  end
  assign keyIrq = keyIrq_reg;

  // ----------------------------------------
  // Wake request
  // ----------------------------------------
  // Wake follows keyIrq_reg with no flop of its own; bit0 standby, bit1 idle
  assign wakeReq = keyIrq_reg && |wakeEn_reg;

  // ----------------------------------------
  // Sticky status
  // ----------------------------------------
  // Set wins over a clear in the same cycle, so a held key is never lost
  // Bit 0 is set by the level, bit 1 marks only a new press
  logic [KMS_STAT_W-1:0] statSet;
  logic [KMS_STAT_W-1:0] statClr;
  always_comb begin
    statSet = '0;
    statSet[KMS_STAT_KEY] = keyIrq_reg;
    statSet[KMS_STAT_ROW] = keyIrq_reg && !keyIrqPrev_reg;
    statClr = wrHit(wrEn, paddr, KMS_OFF_CLEAR) ? pwdata[KMS_STAT_W-1:0] : '0;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_reg <= KMS_STAT_RST;
    end else begin
      status_reg <= (status_reg & ~statClr) | statSet;
    end
  end
  assign irq = |(status_reg & enable_reg);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Unmapped and write-only offsets read as zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (rdEn) begin
      unique case (paddr)
        KMS_OFF_COLCTRL: prdata <= 32'(colMode_reg) | (32'(colIndex_reg) << KMS_COLIX_LSB);
        KMS_OFF_ROWSEL:  prdata <= 32'(rowSel_reg);
        KMS_OFF_ROWIN:   prdata <= 32'(rowSync_reg);
        KMS_OFF_STATUS:  prdata <= 32'(status_reg);
        KMS_OFF_ENABLE:  prdata <= 32'(enable_reg);
        KMS_OFF_WAKE:    prdata <= 32'(wakeEn_reg);
        default:         prdata <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Column driver
  // ----------------------------------------
  // Strobing one column at a time and reading rows scans 8x8 directly
  // The driver adds one flop, so a new mode reaches the pins two edges after the write
  kms_col_driver #(
    .COLS(COLS)
  ) u_col (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .colMode  (colMode_reg),
    .colIndex (colIndex_reg),
    .colOut   (colOut),
    .colOe    (colOe)
  );
endmodule // kms_scanner

// file: kms_key_matrix.sv
// Purpose: Passive 8x8 key switch matrix model
// Assumes: Rows pulled low when no driven column reaches them
// Notes:   keyDown bit r*8+c joins row r to column c
`timescale 1ns/1ns
module kms_key_matrix (
  input  wire logic [63:0] keyDown,
  input  wire logic [7:0]  colOut,
  input  wire logic [7:0]  colOe,
  output logic      [7:0]  rowOut
);
  always_comb begin
    rowOut = 8'h00;
    for (int i = 0; i < 64; i++)
      rowOut[i/8] |= keyDown[i] & colOe[i%8] & colOut[i%8];
  end
endmodule // kms_key_matrix

// file: kms_scanner_asserts.sv
// Purpose: Port checks of the keypad scanner
// Assumes: Zero wait state APB
// Notes:   Bound into every scanner
`timescale 1ns/1ns
module kms_scanner_asserts #(
  parameter int ROWS = 8,
  parameter int COLS = 8
) (
  input wire logic            ref_clk,
  input wire logic            rst_n,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [ROWS-1:0] rowSensePort,
  input wire logic            rowIsInput,
  input wire logic [COLS-1:0] colOe,
  input wire logic [COLS-1:0] colOut,
  input wire logic            keyIrq,
  input wire logic            wakeReq,
  input wire logic            irq
);
  import kms_pkg::*;
  wire wr = psel && penable && pwrite;
  wire colWr = wr && paddr == KMS_OFF_COLCTRL;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Pins follow a column write two edges later: mode register, then driver flop
  a_col_single: assert property (colWr && pwdata[1:0] == 2'h3 |-> ##2
    colOe == COLS'(1) << $past(pwdata[6:4], 2) && colOut == colOe) else $error("single column wrong");
  a_col_low: assert property (colWr && pwdata[1:0] == 2'h1 |-> ##2 colOe == '1 && colOut == '0)
    else $error("all low wrong");
  a_col_high: assert property (colWr && pwdata[1:0] == 2'h2 |-> ##2 colOe == '1 && colOut == '1)
    else $error("all high wrong");
  a_col_hiz: assert property (colWr && pwdata[1:0] == 2'h0 |-> ##2 colOe == '0) else $error("hiz wrong");
  a_col_shape: assert property (colOe == '0 || colOe == '1 || $onehot(colOe))
    else $error("column enables mixed");
  a_rows_off: assert property (!rowIsInput [*3] |=> !keyIrq) else $error("key irq without input");
  a_rows_zero: assert property (rowSensePort == '0 [*3] |=> !keyIrq) else $error("key irq no row");
  a_irq_mask: assert property (wr && paddr == KMS_OFF_ENABLE && pwdata == 32'h0 |-> ##[1:2] !irq)
    else $error("masked irq high");
  a_wake_key: assert property (!keyIrq |-> !wakeReq) else $error("wake without key");
endmodule // kms_scanner_asserts
bind kms_scanner kms_scanner_asserts #(.ROWS(ROWS), .COLS(COLS)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rowSensePort(rowSensePort),
  .rowIsInput(rowIsInput), .colOe(colOe), .colOut(colOut), .keyIrq(keyIrq), .wakeReq(wakeReq), .irq(irq));

// file: kms_scanner_tb.sv
// Purpose: Self-checking bench for the keypad scanner
// Assumes: Zero wait state APB
// Notes:   Key matrix model feeds the rows
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module kms_scanner_tb;
  import kms_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rowIsInput = 1'b1;
  logic [7:0]  paddr = 8'h00, rowSensePort, colOut, colOe;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [63:0] keyDown = 64'h0;
  logic        pready, pslverr, keyIrq, wakeReq, irq, err;
  int          n_fail = 0, n_compared = 0;
  always #2 ref_clk = ~ref_clk;
  kms_scanner uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rowSensePort(rowSensePort), .rowIsInput(rowIsInput), .colOut(colOut), .colOe(colOe),
    .keyIrq(keyIrq), .wakeReq(wakeReq), .irq(irq));
  kms_key_matrix km (.keyDown(keyDown), .colOut(colOut), .colOe(colOe), .rowOut(rowSensePort));
  task automatic summarize();
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(1);
    `CHK({colOe, keyIrq, irq}, 10'h000)
    apb(1'b0, KMS_OFF_ROWSEL, 32'h0);
    `CHK(rd, 32'hff)
    `CHK(err, 1'b0)
    apb(1'b0, KMS_OFF_WAKE, 32'h0);
    `CHK(rd, 32'h3)
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, KMS_OFF_COLCTRL, 32'(c * 16 + 3));
      keyDown <= 64'h1 << (c * 9);
      tick(5);
      `CHK(colOe, 8'h01 << c)
      `CHK(colOut, 8'h01 << c)
      `CHK(keyIrq, 1'b1)
      apb(1'b0, KMS_OFF_ROWIN, 32'h0);
      `CHK(rd, 32'h1 << c)
    end
    apb(1'b0, KMS_OFF_COLCTRL, 32'h0);
    `CHK(rd, 32'h73)
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, KMS_OFF_COLCTRL, 32'(m));
      keyDown <= '1;
      tick(5);
      `CHK(colOe, (m == 0) ? 8'h00 : 8'hff)
      `CHK(colOut & colOe, (m == 2) ? 8'hff : 8'h00)
      `CHK(keyIrq, m == 2)
    end
    apb(1'b1, KMS_OFF_ROWSEL, 32'h0);
    tick(5);
    `CHK(keyIrq, 1'b0)
    apb(1'b1, KMS_OFF_ROWSEL, 32'h8);
    keyDown <= 64'h1 << 24;
    tick(5);
    `CHK(keyIrq, 1'b1)
    apb(1'b1, KMS_OFF_ENABLE, 32'h1);
    rowIsInput <= 1'b0;
    tick(5);
    `CHK({keyIrq, wakeReq, irq}, 3'h1)
    apb(1'b0, KMS_OFF_STATUS, 32'h0);
    `CHK(rd, 32'h3)
    apb(1'b1, KMS_OFF_CLEAR, 32'h3);
    tick(2);
    `CHK(irq, 1'b0)
    apb(1'b0, KMS_OFF_STATUS, 32'h0);
    `CHK(rd, 32'h0)
    rowIsInput <= 1'b1;
    tick(5);
    `CHK({wakeReq, irq}, 2'h3)
    apb(1'b1, KMS_OFF_CLEAR, 32'h3);
    apb(1'b0, KMS_OFF_STATUS, 32'h0);
    `CHK(rd, 32'h1)
    apb(1'b1, KMS_OFF_ENABLE, 32'h0);
    tick(2);
    `CHK(irq, 1'b0)
    apb(1'b1, KMS_OFF_WAKE, 32'h0);
    tick(2);
    `CHK(wakeReq, 1'b0)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    summarize();
  end
endmodule // kms_scanner_tb
